// file: rtl/tzt_consts.svh
// named constants for the transfer and zero-test datapath
// assumes a 32-bit apb slave with byte addresses in an 8-bit window
`ifndef TZT_CONSTS_SVH
`define TZT_CONSTS_SVH

// register byte offsets
`define TZT_OFF_CMD     8'h00
`define TZT_OFF_STATUS  8'h04
`define TZT_OFF_CFG     8'h08
`define TZT_OFF_A_EXT   8'h0c
`define TZT_OFF_A_MID   8'h10
`define TZT_OFF_A_LOW   8'h14
`define TZT_OFF_B_EXT   8'h18
`define TZT_OFF_B_MID   8'h1c
`define TZT_OFF_B_LOW   8'h20
`define TZT_OFF_X0      8'h24
`define TZT_OFF_Y0      8'h28
`define TZT_OFF_Y1      8'h2c
`define TZT_OFF_MEM_IN  8'h30
`define TZT_OFF_MEM_OUT 8'h34
`define TZT_OFF_BUSY    8'h38

// command word layout
`define TZT_CMD_START   31
`define TZT_CMD_W       14

// status register bits
`define TZT_SR_C        0
`define TZT_SR_V        1
`define TZT_SR_Z        2
`define TZT_SR_N        3
`define TZT_SR_U        4
`define TZT_SR_E        5
`define TZT_SR_L        6
`define TZT_SR_SZ       7
`define TZT_SR_WMASK    16'h83ff
`define TZT_SR_RESET    16'h0000

// timing: oscillator clocks per plain instruction, one clock here
`define TZT_BASE_OSC    2
`define TZT_CLK_PER_OSC 1
`define TZT_BASE_CYC    (`TZT_BASE_OSC * `TZT_CLK_PER_OSC)

// saturation limits
`define TZT_SAT_POS36   36'h0_7fff_ffff
`define TZT_SAT_NEG36   36'hf_8000_0000
`define TZT_SAT_POS16   16'h7fff
`define TZT_SAT_NEG16   16'h8000

`endif

// file: rtl/tzt_core.sv
// transfer and zero-test datapath with its register file
// assumes an apb master on CLK_SYS; one clock equals one oscillator clock
`timescale 1ns/100ps

// What this block does
// RL1: data word into accumulator, two clocks
// RL2: accumulator to accumulator copies all 36 bits
// RL3: parallel move shares the single instruction
// RL4: time is two clocks plus move cycles
// RL5: software keeps alu and move destinations apart
// RL6: accumulator test changes flags only
// RL7: accumulator test ignores clamp enable
// RL8: negative is bit 35, zero on zero
// RL9: extension flag from extension bits; v,c cleared
// RL10: limit from move limiting; size flag standard
// RL11: word test checks 16 bits, stores nothing
// RL12: word test limits accumulator with extension used
// RL13: word test leaves extension flag alone
// RL14: word test negative is word bit 15
// RL15: status register field layout fixed
// RL16: 16-bit source sign-extended, low zeros appended
// RL17: transfer clamps when enabled, touches l,sz
// RL18: parallel read of accumulator delivers limited word
module tzt_core
    import tzt_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // core state
    output logic             BUSY
);

    // architectural state
    logic [35:0]   acc_a;          // accumulator a
    logic [35:0]   acc_b;          // accumulator b
    logic [15:0]   x0;             // data register x0
    logic [15:0]   y0;             // data register y0
    logic [15:0]   y1;             // data register y1
    logic [15:0]   status_register; // mode and condition bits
    logic          clamp_enable;   // saturation on transfers
    logic [15:0]   mem_in;         // word from data memory
    logic [15:0]   mem_out;        // word toward data memory
    tzt_cmd_type   cmd;            // latched instruction
    tzt_state_type state;          // sequencer
    tzt_state_type next_state;     // sequencer next
    logic [2:0]    mv_cnt;         // remaining move cycles

    // bus decode
    logic          setup;          // apb setup phase
    logic          wr_en;          // write accepted
    logic          mapped;         // address hits a register
    logic [31:0]   rd_mux;         // read data before register

    // datapath
    logic          commit;         // last cycle of instruction
    logic          src_is_acc;     // operand is a or b
    logic [35:0]   src_acc;        // selected accumulator
    tzt_lim_type   test_lim;       // limited test operand
    tzt_lim_type   move_lim;       // limited move operand
    logic [35:0]   move_acc;       // accumulator read by a move
    logic          move_acc_src;   // move reads a full accumulator
    logic [15:0]   move_word;      // word put to memory
    logic [15:0]   test_word;      // word under test
    logic [35:0]   tfr_val;        // transfer result
    logic [15:0]   next_status;    // flags at commit

    // handshake outputs
    assign PREADY = 1'b1;
    assign BUSY   = (state != ST_IDLE);

    assign setup  = PSEL & ~PENABLE;
    assign wr_en  = PSEL & PENABLE & PWRITE & ~BUSY;

    // address decode and read mux
    always_comb
    begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (PADDR)
            `TZT_OFF_CMD:     rd_mux = {18'h0, cmd};
            `TZT_OFF_STATUS:  rd_mux = {16'h0000, status_register};
            `TZT_OFF_CFG:     rd_mux = {31'h0000_0000, clamp_enable};
            `TZT_OFF_A_EXT:   rd_mux = {28'h000_0000, acc_a[35:32]};
            `TZT_OFF_A_MID:   rd_mux = {16'h0000, acc_a[31:16]};
            `TZT_OFF_A_LOW:   rd_mux = {16'h0000, acc_a[15:0]};
            `TZT_OFF_B_EXT:   rd_mux = {28'h000_0000, acc_b[35:32]};
            `TZT_OFF_B_MID:   rd_mux = {16'h0000, acc_b[31:16]};
            `TZT_OFF_B_LOW:   rd_mux = {16'h0000, acc_b[15:0]};
            `TZT_OFF_X0:      rd_mux = {16'h0000, x0};
            `TZT_OFF_Y0:      rd_mux = {16'h0000, y0};
            `TZT_OFF_Y1:      rd_mux = {16'h0000, y1};
            `TZT_OFF_MEM_IN:  rd_mux = {16'h0000, mem_in};
            `TZT_OFF_MEM_OUT: rd_mux = {16'h0000, mem_out};
            `TZT_OFF_BUSY:    rd_mux = {31'h0000_0000, BUSY};
            default:          mapped = 1'b0;
        endcase
    end

    // read data and error latched in setup
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else if (setup)
        begin
            PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
            PSLVERR <= ~mapped;
        end
    end

    // instruction latch; a start while busy is dropped
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            cmd <= '{op: OP_NONE, default: '0};
        end
        else if (wr_en && PADDR == `TZT_OFF_CMD)
        begin
            cmd <= tzt_cmd_type'(PWDATA[`TZT_CMD_W-1:0]);
        end
    end

    // sequencer: two clocks plus move clocks
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
            begin
                if (wr_en && PADDR == `TZT_OFF_CMD && PWDATA[`TZT_CMD_START])
                begin
                    next_state = ST_EXEC0;
                end
            end
            ST_EXEC0: next_state = ST_EXEC1;
            ST_EXEC1: next_state = (cmd.move_en && cmd.extra != 3'h0) ? ST_WAIT : ST_IDLE; // RL4
            ST_WAIT:  next_state = (mv_cnt == 3'h1) ? ST_IDLE : ST_WAIT;
        endcase
    end

    // state register
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // move cycle counter
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            mv_cnt <= 3'h0;
        end
        else if (state == ST_EXEC1)
        begin
            mv_cnt <= cmd.extra; // RL4
        end
        else if (state == ST_WAIT)
        begin
            mv_cnt <= mv_cnt - 3'h1;
        end
    end

    // one commit for alu and move
    assign commit = (state == ST_EXEC1 && !(cmd.move_en && cmd.extra != 3'h0))
                  || (state == ST_WAIT && mv_cnt == 3'h1); // RL3

    // operand selection
    assign src_is_acc = (cmd.src == 3'h3) || (cmd.src == 3'h4);
    assign src_acc    = (cmd.src == 3'h4) ? acc_b : acc_a;
    assign move_acc   = (cmd.move_reg == 3'h4 || cmd.move_reg == 3'h6) ? acc_b : acc_a;
    assign move_acc_src = (cmd.move_reg == 3'h3) || (cmd.move_reg == 3'h4);

    // limiter shared by both tests
    tzt_limiter u_test_lim
    (
        .acc (src_acc),
        .res (test_lim)
    );

    // limiter on the parallel read path
    tzt_limiter u_move_lim
    (
        .acc (move_acc),
        .res (move_lim)
    );

    // word operand
    always_comb
    begin
        test_word = mem_in;
        unique case (cmd.src)
            3'h0: test_word = x0;
            3'h1: test_word = y0;
            3'h2: test_word = y1;
            3'h3, 3'h4: test_word = test_lim.word; // RL12
            default: test_word = mem_in;
        endcase
    end

    // word a move puts to memory
    always_comb
    begin
        unique case (cmd.move_reg)
            3'h0: move_word = x0;
            3'h1: move_word = y0;
            3'h2: move_word = y1;
            3'h3, 3'h4: move_word = move_lim.word; // RL18
            3'h5, 3'h6: move_word = move_acc[31:16];
            default: move_word = 16'h0000;
        endcase
    end

    // transfer value, clamped only when enabled
    always_comb
    begin
        if (!src_is_acc)
        begin
            tfr_val = {{4{test_word[15]}}, test_word, 16'h0000}; // RL16 RL1
        end
        else if (clamp_enable && test_lim.ext_used)
        begin
            tfr_val = src_acc[35] ? `TZT_SAT_NEG36 : `TZT_SAT_POS36; // RL17
        end
        else
        begin
            tfr_val = src_acc; // RL2
        end
    end

    // condition flags at commit
    always_comb
    begin
        next_status = status_register;
        unique case (cmd.op)
            OP_TST:
            begin
                // clamp_enable deliberately unused here
                next_status[`TZT_SR_N] = src_acc[35]; // RL8 RL7
                next_status[`TZT_SR_Z] = (src_acc == 36'h0_0000_0000); // RL8
                next_status[`TZT_SR_E] = test_lim.ext_used; // RL9
                next_status[`TZT_SR_U] = ~(src_acc[31] ^ src_acc[30]);
                next_status[`TZT_SR_V] = 1'b0; // RL9
                next_status[`TZT_SR_C] = 1'b0; // RL9
            end
            OP_WORD_ZERO_TEST:
            begin
                // extension flag left as it was
                next_status[`TZT_SR_N] = test_word[15]; // RL14 RL13
                next_status[`TZT_SR_Z] = (test_word == 16'h0000); // RL11
                next_status[`TZT_SR_V] = 1'b0; // RL13
                next_status[`TZT_SR_C] = 1'b0; // RL13
                if (src_is_acc && test_lim.limited)
                begin
                    next_status[`TZT_SR_L] = 1'b1; // RL12
                end
            end
            default:
            begin
                // transfer touches only l and sz, below
            end
        endcase
        // parallel read of a full accumulator: limit and size
        if (cmd.move_en && !cmd.move_rd && move_acc_src)
        begin
            if (move_lim.limited)
            begin
                next_status[`TZT_SR_L] = 1'b1; // RL10 RL17
            end
            if (move_acc[30] ^ move_acc[29])
            begin
                next_status[`TZT_SR_SZ] = 1'b1; // RL10
            end
        end
    end

    // status: flags at commit, else bus writes
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            status_register <= `TZT_SR_RESET;
        end
        else if (commit)
        begin
            status_register <= next_status & `TZT_SR_WMASK; // RL15
        end
        else if (wr_en && PADDR == `TZT_OFF_STATUS)
        begin
            status_register <= PWDATA[15:0] & `TZT_SR_WMASK; // RL15
        end
    end

    // configuration
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            clamp_enable <= 1'b0;
        end
        else if (wr_en && PADDR == `TZT_OFF_CFG)
        begin
            clamp_enable <= PWDATA[0];
        end
    end

    // memory side words
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            mem_in  <= 16'h0000;
            mem_out <= 16'h0000;
        end
        else
        begin
            if (wr_en && PADDR == `TZT_OFF_MEM_IN)
            begin
                mem_in <= PWDATA[15:0];
            end
            if (commit && cmd.move_en && !cmd.move_rd)
            begin
                mem_out <= move_word; // RL18
            end
        end
    end

    // data registers: bus load, or parallel memory read
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            x0 <= 16'h0000;
            y0 <= 16'h0000;
            y1 <= 16'h0000;
        end
        else if (commit && cmd.move_en && cmd.move_rd)
        begin
            // only the named register changes
            if (cmd.move_reg == 3'h0)
            begin
                x0 <= mem_in;
            end
            if (cmd.move_reg == 3'h1)
            begin
                y0 <= mem_in;
            end
            if (cmd.move_reg == 3'h2)
            begin
                y1 <= mem_in;
            end
        end
        else if (wr_en)
        begin
            if (PADDR == `TZT_OFF_X0)
            begin
                x0 <= PWDATA[15:0];
            end
            if (PADDR == `TZT_OFF_Y0)
            begin
                y0 <= PWDATA[15:0];
            end
            if (PADDR == `TZT_OFF_Y1)
            begin
                y1 <= PWDATA[15:0];
            end
        end
    end

    // accumulators; move read applied last,
    // so on a clash the move wins
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            acc_a <= 36'h0_0000_0000;
            acc_b <= 36'h0_0000_0000;
        end
        else if (commit)
        begin
            if (cmd.op == OP_TFR)
            begin
                // tests store nothing
                if (cmd.dst_b)
                begin
                    acc_b <= tfr_val; // RL2 RL6 RL11
                end
                else
                begin
                    acc_a <= tfr_val; // RL1
                end
            end
            if (cmd.move_en && cmd.move_rd)
            begin
                // RL5
                unique case (cmd.move_reg)
                    3'h3: acc_a <= {{4{mem_in[15]}}, mem_in, 16'h0000};
                    3'h4: acc_b <= {{4{mem_in[15]}}, mem_in, 16'h0000};
                    3'h5: acc_a[31:16] <= mem_in;
                    3'h6: acc_b[31:16] <= mem_in;
                    default:
                    begin
                    end
                endcase
            end
        end
        else if (wr_en)
        begin
            unique case (PADDR)
                `TZT_OFF_A_EXT: acc_a[35:32] <= PWDATA[3:0];
                `TZT_OFF_A_MID: acc_a[31:16] <= PWDATA[15:0];
                `TZT_OFF_A_LOW: acc_a[15:0]  <= PWDATA[15:0];
                `TZT_OFF_B_EXT: acc_b[35:32] <= PWDATA[3:0];
                `TZT_OFF_B_MID: acc_b[31:16] <= PWDATA[15:0];
                `TZT_OFF_B_LOW: acc_b[15:0]  <= PWDATA[15:0];
                default:
                begin
                end
            endcase
        end
    end

endmodule

// file: rtl/tzt_limiter.sv
// 36-bit accumulator to 16-bit limiter
// pure combinational, used for word tests and parallel reads
`timescale 1ns/100ps

module tzt_limiter
    import tzt_pkg::*;
(
    // accumulator in
    input  wire logic [35:0] acc,
    // limited word out
    output tzt_lim_type      res
);

    logic ext_used; // extension bits carry value

    // extension in use when bits 35..31 are not all equal
    assign ext_used = ~((&acc[35:31]) | ~(|acc[35:31]));

    // clamp toward the sign of the full value
    always_comb
    begin
        res.ext_used = ext_used;
        res.limited  = ext_used;
        if (!ext_used)
        begin
            res.word = acc[31:16];
        end
        else if (acc[35])
        begin
            res.word = `TZT_SAT_NEG16;
        end
        else
        begin
            res.word = `TZT_SAT_POS16;
        end
    end

endmodule

// file: rtl/tzt_pkg.sv
// types shared by the transfer and zero-test datapath
// assumes tzt_consts.svh is on the include path
`include "tzt_consts.svh"

package tzt_pkg;

    // instruction selector
    typedef enum logic [1:0]
    {
        OP_TFR  = 2'h0,
        OP_TST  = 2'h1,
        OP_WORD_ZERO_TEST = 2'h2,
        OP_NONE = 2'h3
    } tzt_op_type;

    // operand sources: 0 x0, 1 y0, 2 y1, 3 a, 4 b, 5 memory word
    // move registers: 0 x0, 1 y0, 2 y1, 3 a, 4 b, 5 a middle, 6 b middle
    typedef struct packed
    {
        tzt_op_type op;
        logic [2:0] src;
        logic       dst_b;
        logic       move_en;
        logic       move_rd;
        logic [2:0] move_reg;
        logic [2:0] extra;
    } tzt_cmd_type;

    // sequencer, gray coded along idle-exec0-exec1-wait
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_EXEC0 = 2'b01,
        ST_EXEC1 = 2'b11,
        ST_WAIT  = 2'b10
    } tzt_state_type;

    // limiter results travel together
    typedef struct packed
    {
        logic [15:0] word;
        logic        limited;
        logic        ext_used;
    } tzt_lim_type;

endpackage

// file: tb/tzt_core_properties.sv
// checker for the transfer and zero-test core, sees only its ports
// assumes zero wait-state apb
`timescale 1ns/100ps
`include "tzt_consts.svh"

module tzt_core_checker
    import tzt_pkg::*;
(
    // clock and reset
    input wire logic        CLK_SYS,
    input wire logic        RST,
    // apb slave
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // core state
    input wire logic        BUSY
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    logic       setup;     // apb setup cycle
    logic       start;     // accepted instruction start
    logic       unmapped;  // not in the map
    logic [3:0] busy_cnt;  // cycles seen busy
    logic [3:0] busy_len;  // cycles the command asks for

    assign setup    = PSEL && !PENABLE;
    assign start    = PSEL && PENABLE && PWRITE && !BUSY && PADDR == `TZT_OFF_CMD
                      && PWDATA[`TZT_CMD_START];
    assign unmapped = PADDR[1:0] != 2'h0 || PADDR > `TZT_OFF_BUSY;

    // run length latched at start
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            busy_cnt <= 4'h0;
            busy_len <= 4'h0;
        end
        else if (start)
        begin
            busy_cnt <= 4'h0;
            busy_len <= 4'h2 + (PWDATA[7] ? {1'b0, PWDATA[2:0]} : 4'h0);
        end
        else if (BUSY)
        begin
            busy_cnt <= busy_cnt + 4'h1;
        end
    end

    AST_READY: assert property (PSEL && PENABLE |-> PREADY)
        else $error("pready low in access");
    AST_PLAIN_RUN: assert property (start && !PWDATA[7] |=> BUSY [*2] ##1 !BUSY)
        else $error("plain run not two cycles");
    AST_RUN_LENGTH: assert property ($fell(BUSY) |-> busy_cnt == busy_len)
        else $error("run length wrong");
    AST_BUSY_CAUSE: assert property ($rose(BUSY) |-> $past(start))
        else $error("busy without a start");
    AST_SR_RESERVED: assert property (setup && !PWRITE && PADDR == `TZT_OFF_STATUS
        |=> PRDATA[31:16] == 16'h0 && PRDATA[14:10] == 5'h0)
        else $error("status reserved bits set");
    AST_CMD_READBACK: assert property (setup && !PWRITE && PADDR == `TZT_OFF_CMD
        |=> PRDATA[31:14] == 18'h0)
        else $error("cmd readback upper bits");
    AST_UNMAPPED: assert property (setup && unmapped
        |=> PSLVERR && (PWRITE || PRDATA == 32'h0))
        else $error("unmapped not refused");
    AST_MAPPED: assert property (setup && !unmapped |=> !PSLVERR)
        else $error("mapped access erred");

    COV_MOVE_RUN: cover property (start && PWDATA[7] && PWDATA[2:0] != 3'h0);
    COV_SR_READ: cover property (setup && !PWRITE && PADDR == `TZT_OFF_STATUS);
    COV_UNMAPPED: cover property (setup && unmapped);
endmodule

bind tzt_core tzt_core_checker chk (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .BUSY(BUSY));

// file: tb/tzt_testbench.sv
// self-checking bench for the transfer and zero-test core
// assumes apb on CLK_SYS, busy polled
`timescale 1ns/100ps
`include "tzt_consts.svh"

module testbench
    import tzt_pkg::*;
;
    logic        clk_sys = 1'b0;  // 100 MHz
    logic        rst     = 1'b1;  // held two cycles
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy;
    int          fails   = 0;
    int          num_checks = 0;
    int          cycles  = 0;

    tzt_core dut (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .BUSY(busy));

    always #5 clk_sys = ~clk_sys;

    // hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            summarize();
        end
    end

    task summarize;
        if (fails == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task check(input string what, input logic [35:0] exp, input logic [35:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, held until pready
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        xfer(1'b1, a, d, rd, e);
    endtask

    task rd(input logic [7:0] a, output logic [31:0] v);
        logic e;
        xfer(1'b0, a, 32'h0, v, e);
    endtask

    task set_acc(input logic b, input logic [35:0] v);
        logic [7:0] base;
        base = b ? `TZT_OFF_B_EXT : `TZT_OFF_A_EXT;
        wr(base, {28'h0, v[35:32]});
        wr(base + 8'h4, {16'h0, v[31:16]});
        wr(base + 8'h8, {16'h0, v[15:0]});
    endtask

    task get_acc(input logic b, output logic [35:0] v);
        logic [31:0] e, m, l;
        rd(b ? `TZT_OFF_B_EXT : `TZT_OFF_A_EXT, e);
        rd(b ? `TZT_OFF_B_MID : `TZT_OFF_A_MID, m);
        rd(b ? `TZT_OFF_B_LOW : `TZT_OFF_A_LOW, l);
        v = {e[3:0], m[15:0], l[15:0]};
    endtask

    function logic [31:0] cmd(input logic [1:0] op, input logic [2:0] src,
        input logic dst, input logic men, input logic mrd, input logic [2:0] mreg,
        input logic [2:0] ex);
        return {1'b1, 17'h0, op, src, dst, men, mrd, mreg, ex};
    endfunction

    // start and poll busy
    task run(input logic [31:0] c);
        logic [31:0] v;
        wr(`TZT_OFF_CMD, c);
        v = 32'h1;
        for (int i = 0; i < 20 && v[0] !== 1'b0; i++)
            rd(`TZT_OFF_BUSY, v);
        check("busy_done", 36'h0, v[0]);
    endtask

    // status after a run
    task sr_after(input logic [15:0] pre, input logic [31:0] c, output logic [31:0] v);
        wr(`TZT_OFF_STATUS, {16'h0, pre});
        run(c);
        rd(`TZT_OFF_STATUS, v);
    endtask

    task t_regs;
        logic [31:0] v;
        logic        e;
        rd(`TZT_OFF_STATUS, v);
        check("status_reset", 36'h0, v);
        xfer(1'b0, 8'h3c, 32'h0, v, e);
        check("unmap_err", 36'h1, e);
        check("unmap_data", 36'h0, v);
        xfer(1'b1, 8'h02, 32'h1, v, e);
        check("misalign_err", 36'h1, e);
        wr(`TZT_OFF_STATUS, 32'hffff_ffff);
        rd(`TZT_OFF_STATUS, v);
        check("status_mask", 36'h83ff, v);
    endtask

    task t_transfer;
        logic [35:0] a;
        logic [31:0] v;
        wr(`TZT_OFF_X0, 32'h8001);
        run(cmd(OP_TFR, 3'h0, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0));
        get_acc(1'b0, a);
        check("acc_from_word", 36'hf_8001_0000, a);
        set_acc(1'b0, 36'h3_0123_0123);
        sr_after(16'h000f, cmd(OP_TFR, 3'h3, 1'b1, 1'b0, 1'b0, 3'h0, 3'h0), v);
        get_acc(1'b1, a);
        check("acc_copy", 36'h3_0123_0123, a);
        check("tfr_flags", 36'h000f, v);
        wr(`TZT_OFF_CFG, 32'h1);
        run(cmd(OP_TFR, 3'h3, 1'b1, 1'b0, 1'b0, 3'h0, 3'h0));
        get_acc(1'b1, a);
        check("acc_clamped", 36'h0_7fff_ffff, a);
        run(cmd(OP_TFR, 3'h4, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0));
        get_acc(1'b0, a);
        check("acc_copy_back", 36'h0_7fff_ffff, a);
        wr(`TZT_OFF_CFG, 32'h0);
    endtask

    task t_acc_test;
        logic [35:0] a;
        logic [31:0] v;
        for (int s = 0; s < 2; s++)
        begin
            wr(`TZT_OFF_CFG, s);
            set_acc(1'b0, 36'h8_0203_0000);
            sr_after(16'h0303, cmd(OP_TST, 3'h3, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0), v);
            check("tst_flags", 36'h0338, v);
            get_acc(1'b0, a);
            check("tst_acc_kept", 36'h8_0203_0000, a);
        end
        wr(`TZT_OFF_CFG, 32'h0);
        set_acc(1'b1, 36'h0);
        sr_after(16'h0300, cmd(OP_TST, 3'h4, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0), v);
        check("tst_zero", 36'h0314, v);
    endtask

    task t_word_test;
        logic [35:0] a;
        logic [31:0] v;
        wr(`TZT_OFF_MEM_IN, 32'hfc00);
        sr_after(16'h0300, cmd(OP_WORD_ZERO_TEST, 3'h5, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0), v);
        check("word_zero_test_neg", 36'h0308, v);
        wr(`TZT_OFF_MEM_IN, 32'h0);
        sr_after(16'h0301, cmd(OP_WORD_ZERO_TEST, 3'h5, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0), v);
        check("word_zero_test_zero", 36'h0304, v);
        set_acc(1'b0, 36'h3_0123_0123);
        sr_after(16'h0320, cmd(OP_WORD_ZERO_TEST, 3'h3, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0), v);
        check("word_zero_test_limited", 36'h0360, v);
        get_acc(1'b0, a);
        check("word_zero_test_acc_kept", 36'h3_0123_0123, a);
    endtask

    task t_moves;
        logic [35:0] a;
        logic [31:0] v;
        set_acc(1'b1, 36'h3_0123_0123);
        set_acc(1'b0, 36'h0_0000_0001);
        sr_after(16'h0000, cmd(OP_TST, 3'h3, 1'b0, 1'b1, 1'b0, 3'h4, 3'h3), v);
        check("move_l_flag", 36'h0050, v);
        rd(`TZT_OFF_MEM_OUT, v);
        check("move_lim_word", 36'h7fff, v);
        wr(`TZT_OFF_MEM_IN, 32'h1234);
        run(cmd(OP_TFR, 3'h0, 1'b0, 1'b1, 1'b1, 3'h2, 3'h0));
        rd(`TZT_OFF_Y1, v);
        check("move_read", 36'h1234, v);
        get_acc(1'b0, a);
        check("move_tfr", 36'hf_8001_0000, a);
        set_acc(1'b1, 36'h0_4000_0000);
        sr_after(16'h0000, cmd(OP_TST, 3'h3, 1'b0, 1'b1, 1'b0, 3'h4, 3'h1), v);
        check("move_sz_flag", 36'h0088, v);
        rd(`TZT_OFF_MEM_OUT, v);
        check("move_word", 36'h4000, v);
    endtask

    // writes while busy are dropped
    task t_busy_block;
        logic [31:0] v;
        wr(`TZT_OFF_STATUS, 32'h0);
        wr(`TZT_OFF_CMD, cmd(OP_TST, 3'h3, 1'b0, 1'b1, 1'b0, 3'h0, 3'h7));
        wr(`TZT_OFF_STATUS, 32'hffff);
        run(cmd(OP_WORD_ZERO_TEST, 3'h5, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0));
        rd(`TZT_OFF_STATUS, v);
        check("busy_wr_dropped", 36'h0008, v);
        rd(`TZT_OFF_MEM_OUT, v);
        check("busy_move_out", 36'h8001, v);
    endtask

    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs;
        t_transfer;
        t_acc_test;
        t_word_test;
        t_moves;
        t_busy_block;
        summarize();
    end
endmodule
